// ==== verilog/sdr_pkg.sv ====
// Shared constants and carrier types for the segment display refresh block.
package sdr_pkg;

   // Geometry of the display memory.
   localparam int unsigned SDR_CHARS      = 32;
   localparam int unsigned SDR_BYTES      = 64;
   localparam int unsigned SDR_ADDR_W     = 6;
   localparam int unsigned SDR_DATA_W     = 8;
   localparam int unsigned SDR_CHAR_W     = 5;
   localparam int unsigned SDR_FIFO_DEPTH = 8;

   // Address bit that picks word 0 or word 1 of a character.
   localparam int unsigned SDR_WORD_BIT = 0;

   // Timing: clock rate and whole-display refresh rate.
   localparam int unsigned SDR_CLK_HZ     = 100_000_000;
   localparam int unsigned SDR_REFRESH_HZ = 130;
   localparam int unsigned SDR_PHASES     = 4;
   // Clock cycles per phase, rounded down so the refresh is never slower.
   localparam int unsigned SDR_PHASE_CYC  =
      SDR_CLK_HZ / (SDR_REFRESH_HZ * SDR_CHARS * SDR_PHASES);

   // Phase codes inside one digit slot; phase 0 is the blanked fetch.
   localparam logic [1:0] SDR_PH_BLANK = 2'h0;
   localparam logic [1:0] SDR_PH_LAST  = 2'h3;

   // Segment drive level that leaves a segment dark.
   localparam logic [7:0] SDR_SEG_OFF = 8'hff;

   // One host write: address and data byte.
   typedef struct packed {
      logic [SDR_ADDR_W-1:0] addr;
      logic [SDR_DATA_W-1:0] data;
   } sdr_wr_t;

   // Segment outputs of the lit character, all active low.
   typedef struct packed {
      logic [7:0] word1;
      logic [7:0] word0;
   } sdr_seg_t;

   // States of the host write catcher.
   typedef enum logic [1:0] {
      SDR_IDLE  = 2'b00,
      SDR_ARMED = 2'b01,
      SDR_DONE  = 2'b11
   } sdr_wst_t;

endpackage

// ==== verilog/sdr_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sdr_fifo #(
   parameter int unsigned WIDTH = 14,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);

   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];   // Entry storage.
   logic [PW-1:0]    wrPtr_q;         // Next entry to fill.
   logic [PW-1:0]    rdPtr_q;         // Next entry to drain.
   logic [PW:0]      count_q;         // Entries held.
   logic             push;
   logic             pop;

   // Honest full and empty flags from the entry count.
   assign inReady  = (count_q != (PW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = store[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Entry writes need no reset.
   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtr_q] <= inData;
      end
   end

   // Pointers wrap naturally at a power-of-two depth.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule

// ==== verilog/sdr_ram.sv ====
// Display memory with one write port and one registered read port.
`timescale 1ns/10ps
module sdr_ram #(
   parameter int unsigned AW = 6,
   parameter int unsigned DW = 8
) (
   input  wire logic          clk,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0]      rdData
);

   logic [DW-1:0] mem [2**AW];   // The display bytes.

   // Write and registered read share the clock.
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule

// ==== verilog/sdr_refresh.sv ====
// Scanning refresh controller for a 32-character segment display.
`timescale 1ns/10ps
module sdr_refresh
   import sdr_pkg::*;
#(
   parameter int unsigned PHASE_CYC = SDR_PHASE_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  chipSelect_n,
   input  wire logic                  write_n,
   input  wire logic [SDR_ADDR_W-1:0] hostAddr,
   input  wire logic [SDR_DATA_W-1:0] hostData,
   output logic [SDR_CHARS-1:0]       digitEn_q,
   output logic [7:0]                 segLow_q,
   output logic [7:0]                 segHigh_q,
   output logic                       displayOn_q,
   output logic                       writeBusy_q
);

   localparam int unsigned SYNC_W = 2 + SDR_ADDR_W + SDR_DATA_W;
   localparam int unsigned CW     = $clog2(PHASE_CYC + 1);

   // Three-stage synchronisers for the asynchronous host pins.
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync3_q;
   logic [SYNC_W-1:0] stable_q;   // Pin values once stages two and three agree.

   // Host write path.
   sdr_wst_t wState_q;            // Write catcher state.
   sdr_wr_t  wrCatch;             // Captured write for the FIFO.
   logic     wrPush;              // Write strobe rose inside a select.
   logic     fifoInReady;         // FIFO has room.
   sdr_wr_t  fifoOut;             // Oldest pending write.
   logic     fifoOutValid;        // A write is pending.
   logic     ramWrEn;             // Memory write this cycle.
   logic     ramBusy;             // Memory port given to a write.

   // Scan state.
   logic [CW-1:0]         tick_q;     // Cycle count inside a phase.
   logic                  phaseEn;    // One-cycle pulse at end of a phase.
   logic [1:0]            phase_q;    // Phase inside the digit slot.
   logic [SDR_CHAR_W-1:0] char_q;     // Character being scanned.
   logic [SDR_ADDR_W-1:0] scanAddr;   // Address the scan fetches.
   logic [SDR_DATA_W-1:0] rdData;     // Registered memory read data.
   logic [SDR_DATA_W-1:0] hold_q;     // Word 0 holding register.
   logic                  readOk_q;   // Read data belongs to the scan.
   logic [1:0]            readPh_q;   // Phase the read data was fetched in.
   logic                  selNow;     // Host select is active.
   logic                  csSeen_q;   // Select active last cycle.

   // Catch the pins in three flops; a change counts once two and three agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q  <= {2'b11, {(SDR_ADDR_W + SDR_DATA_W){1'b0}}};
         sync2_q  <= {2'b11, {(SDR_ADDR_W + SDR_DATA_W){1'b0}}};
         sync3_q  <= {2'b11, {(SDR_ADDR_W + SDR_DATA_W){1'b0}}};
         stable_q <= {2'b11, {(SDR_ADDR_W + SDR_DATA_W){1'b0}}};
      end else begin
         sync1_q <= {chipSelect_n, write_n, hostAddr, hostData};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // Each bit is updated only when its two late stages match.
         for (int i = 0; i < SYNC_W; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               stable_q[i] <= sync3_q[i];
            end
         end
      end
   end

   // Select is active low on the pin.
   assign selNow = !stable_q[SYNC_W-1];

   // Host write catcher: arm on a falling strobe inside a select, then
   // store on the rising strobe while the host still holds select and
   // address steady.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wState_q <= SDR_IDLE;
      end else begin
         unique case (wState_q)
            SDR_IDLE: begin
               // The host selects first, then pulls the strobe low.
               if (selNow && !stable_q[SYNC_W-2]) begin
                  wState_q <= SDR_ARMED;
               end
            end
            SDR_ARMED: begin
               if (!selNow) begin
                  // Select dropped before the strobe rose: no write.
                  wState_q <= SDR_IDLE;
               end else if (stable_q[SYNC_W-2]) begin
                  wState_q <= SDR_DONE;
               end
            end
            SDR_DONE: begin
               // Return to idle on the next cycle; the strobe is already high here.
               wState_q <= SDR_IDLE;
            end
            default: begin
               wState_q <= SDR_IDLE;
            end
         endcase
      end
   end

   // The write is taken on the rising strobe with select still low.
   assign wrPush       = (wState_q == SDR_ARMED) && selNow && stable_q[SYNC_W-2];
   assign wrCatch.addr = stable_q[SDR_DATA_W +: SDR_ADDR_W];
   assign wrCatch.data = stable_q[0 +: SDR_DATA_W];

   // Pending host writes wait here; the memory drains them between fetches.
   sdr_fifo #(
      .WIDTH (SDR_ADDR_W + SDR_DATA_W),
      .DEPTH (SDR_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inData   (wrCatch),
      .inValid  (wrPush),
      .inReady  (fifoInReady),
      .outData  (fifoOut),
      .outValid (fifoOutValid),
      .outReady (ramBusy)
   );

   // A write takes the memory port only in a phase's non-fetch cycles, blank or lit,
   // so the scan fetch at each phase start is never stolen.
   assign ramBusy = fifoOutValid && !phaseEn && (tick_q != '0);
   assign ramWrEn = ramBusy;

   // Flag that a write is still pending or the FIFO is full.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         writeBusy_q <= 1'b0;
      end else begin
         writeBusy_q <= !fifoInReady || fifoOutValid;
      end
   end

   // Phase timer: a one-cycle enable pulse ends each quarter slot.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= '0;
      end else if (phaseEn) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end
   assign phaseEn = (tick_q == CW'(PHASE_CYC - 1));

   // Phase and character counters run freely, host or no host.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= SDR_PH_BLANK;
         char_q  <= '0;
      end else if (phaseEn) begin
         phase_q <= phase_q + 1'b1;
         if (phase_q == SDR_PH_LAST) begin
            char_q <= char_q + 1'b1;
         end
      end
   end

   // Character in the upper bits, word select in bit zero.
   assign scanAddr = {char_q, (phase_q != SDR_PH_BLANK)};

   // Display memory; the write port serves the host, the read port the scan.
   sdr_ram #(
      .AW (SDR_ADDR_W),
      .DW (SDR_DATA_W)
   ) u_ram (
      .clk    (clk),
      .wrEn   (ramWrEn),
      .wrAddr (fifoOut.addr),
      .wrData (fifoOut.data),
      .rdAddr (scanAddr),
      .rdData (rdData)
   );

   // Track which phase the registered read belongs to.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readOk_q <= 1'b0;
         readPh_q <= SDR_PH_BLANK;
         csSeen_q <= 1'b0;
      end else begin
         readOk_q <= (tick_q == '0);
         readPh_q <= phase_q;
         csSeen_q <= selNow;
      end
   end

   // Word 0 is captured during the blanked phase.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= SDR_SEG_OFF;
      end else if (readOk_q && readPh_q == SDR_PH_BLANK) begin
         hold_q <= rdData;
      end
   end

   // Drive outputs: blank in phase 0, lit otherwise; segments are low true,
   // so the stored bytes go out unchanged.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         digitEn_q   <= '0;
         segLow_q    <= SDR_SEG_OFF;
         segHigh_q   <= SDR_SEG_OFF;
         displayOn_q <= 1'b0;
      end else if (readOk_q) begin
         if (readPh_q == SDR_PH_BLANK) begin
            // Blank while word 0 ripples into the holding register.
            digitEn_q   <= '0;
            segLow_q    <= SDR_SEG_OFF;
            segHigh_q   <= SDR_SEG_OFF;
            displayOn_q <= 1'b0;
         end else begin
            digitEn_q   <= SDR_CHARS'(1) << char_q;
            segLow_q    <= hold_q;
            segHigh_q   <= rdData;
            displayOn_q <= 1'b1;
         end
      end
   end

endmodule

// ==== dv/sdr_refresh_checker.sv ====
// Port-level concurrent checks for the scanning refresh block.
`timescale 1ns/10ps
module sdr_refresh_checker
   import sdr_pkg::*;
#(
   parameter int unsigned PHASE_CYC = SDR_PHASE_CYC
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  chipSelect_n,
   input wire logic                  write_n,
   input wire logic [SDR_ADDR_W-1:0] hostAddr,
   input wire logic [SDR_DATA_W-1:0] hostData,
   input wire logic [SDR_CHARS-1:0]  digitEn_q,
   input wire logic [7:0]            segLow_q,
   input wire logic [7:0]            segHigh_q,
   input wire logic                  displayOn_q,
   input wire logic                  writeBusy_q
);
   logic [31:0]          litCnt_q;    // Cycles lit so far in this slot.
   logic [31:0]          offCnt_q;    // Cycles blanked so far.
   logic [31:0]          frameCnt_q;  // Cycles since digit 0 last lit.
   logic [SDR_CHARS-1:0] lastDig_q;   // Digit that was lit last.
   logic                 seenFall_q;  // A full lit span has ended.
   logic                 frameSeen_q; // Digit 0 has lit once.
   logic                 dig0_q;      // Digit 0 enable one cycle ago.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Phase span counters; spans before the first full one are not judged.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         litCnt_q   <= 32'h0;
         offCnt_q   <= 32'h0;
         lastDig_q  <= '0;
         seenFall_q <= 1'b0;
      end else begin
         litCnt_q   <= displayOn_q ? litCnt_q + 32'h1 : 32'h0;
         offCnt_q   <= displayOn_q ? 32'h0 : offCnt_q + 32'h1;
         lastDig_q  <= displayOn_q ? digitEn_q : lastDig_q;
         seenFall_q <= seenFall_q | (litCnt_q != 32'h0 && !displayOn_q);
      end
   end

   // Whole-frame counter keyed on digit 0 coming on.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frameCnt_q  <= 32'h0;
         frameSeen_q <= 1'b0;
         dig0_q      <= 1'b0;
      end else begin
         dig0_q      <= digitEn_q[0];
         frameCnt_q  <= (digitEn_q[0] && !dig0_q) ? 32'h1 : frameCnt_q + 32'h1;
         frameSeen_q <= frameSeen_q | (digitEn_q[0] && !dig0_q);
      end
   end

   blank_dark_a: assert property (!displayOn_q |-> digitEn_q == '0 &&
      segLow_q == SDR_SEG_OFF && segHigh_q == SDR_SEG_OFF) else $error("blank phase not dark");
   lit_onehot_a: assert property (displayOn_q |-> $onehot(digitEn_q))
      else $error("lit digit enable not one-hot");
   lit_span_a: assert property ($fell(displayOn_q) |-> litCnt_q == 3 * PHASE_CYC)
      else $error("lit span length wrong");
   blank_span_a: assert property (seenFall_q && $rose(displayOn_q) |->
      offCnt_q == PHASE_CYC) else $error("blank span length wrong");
   digit_step_a: assert property (seenFall_q && $rose(displayOn_q) |->
      digitEn_q == {lastDig_q[SDR_CHARS-2:0], lastDig_q[SDR_CHARS-1]})
      else $error("scan did not step to next digit");
   scan_start_a: assert property (!seenFall_q && $rose(displayOn_q) |-> digitEn_q == 32'h1)
      else $error("scan did not start at digit 0");
   digit_hold_a: assert property (displayOn_q && $past(displayOn_q) |-> $stable(digitEn_q))
      else $error("digit changed inside lit span");
   frame_rate_a: assert property (frameSeen_q && digitEn_q[0] && !dig0_q |->
      frameCnt_q == 4 * SDR_CHARS * PHASE_CYC) else $error("frame length wrong");
   busy_drain_a: assert property ($rose(chipSelect_n) |-> ##[0:40] !writeBusy_q)
      else $error("write still pending after deselect");

   cover property ($rose(displayOn_q));
   cover property ($rose(writeBusy_q));
   cover property ($rose(digitEn_q[SDR_CHARS-1]));
endmodule

bind sdr_refresh sdr_refresh_checker #(.PHASE_CYC(PHASE_CYC)) sdr_refresh_checker_inst (
   .clk(clk), .rst_n(rst_n), .chipSelect_n(chipSelect_n), .write_n(write_n),
   .hostAddr(hostAddr), .hostData(hostData), .digitEn_q(digitEn_q), .segLow_q(segLow_q),
   .segHigh_q(segHigh_q), .displayOn_q(displayOn_q), .writeBusy_q(writeBusy_q));

// ==== dv/sdr_host_model.sv ====
// Host bus model that writes bytes into the display memory.
`timescale 1ns/10ps
module sdr_host_model (
   input  wire logic       clk,
   output logic            chipSelect_n,
   output logic            write_n,
   output logic [5:0]      hostAddr,
   output logic [7:0]      hostData
);
   // Idle bus: deselected, with arbitrary address and data.
   initial begin
      chipSelect_n = 1'b1;
      write_n = 1'b1;
      hostAddr = 6'h15;
      hostData = 8'h5a;
   end

   // Spacing longer than the pin synchroniser needs to settle.
   task automatic gap;
      repeat (6) @(negedge clk);
   endtask

   // Mode 0 writes properly, 1 strobes unselected, 2 deselects before strobe rises.
   task automatic hostWrite(input logic [5:0] a, input logic [7:0] d, input int mode);
      @(negedge clk);
      hostAddr = a;
      hostData = d;
      chipSelect_n = (mode == 1);
      gap();
      write_n = 1'b0;
      gap();
      if (mode == 2) begin
         chipSelect_n = 1'b1;
         gap();
      end
      write_n = 1'b1;
      gap();
      chipSelect_n = 1'b1;
      gap();
      // Released lines no longer show the old value.
      hostAddr = ~a;
      hostData = ~d;
      gap();
   endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the scanning refresh block.
`timescale 1ns/10ps
module tb_top;
   import sdr_pkg::*;
   localparam int unsigned PH = 4; // Short phase keeps frames brief.
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        chipSelect_n;
   logic        write_n;
   logic [5:0]  hostAddr;
   logic [7:0]  hostData;
   logic [31:0] digitEn_q;
   logic [7:0]  segLow_q;
   logic [7:0]  segHigh_q;
   logic        displayOn_q;
   logic        writeBusy_q;
   logic [7:0]  mem [64]; // Expected memory image.
   int          n_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;

   always #5 clk = ~clk;

   sdr_host_model sdr_host_model_inst (.clk(clk), .chipSelect_n(chipSelect_n),
      .write_n(write_n), .hostAddr(hostAddr), .hostData(hostData));
   sdr_refresh #(.PHASE_CYC(PH)) sdr_refresh_inst (.clk(clk), .rst_n(rst_n),
      .chipSelect_n(chipSelect_n), .write_n(write_n), .hostAddr(hostAddr),
      .hostData(hostData), .digitEn_q(digitEn_q), .segLow_q(segLow_q),
      .segHigh_q(segHigh_q), .displayOn_q(displayOn_q), .writeBusy_q(writeBusy_q));

   // Compares one value and counts it.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // Waits, bounded, for the lit flag to reach a level.
   task automatic waitOn(input logic v);
      for (int i = 0; i < 40 && displayOn_q !== v; i++) @(negedge clk);
      cmp(32'(displayOn_q), 32'(v));
   endtask

   // Walks one frame from digit 0 and checks every slot.
   task automatic scanFrame;
      for (int i = 0; i < 600 && digitEn_q[0] !== 1'b1; i++) @(negedge clk);
      for (int n = 0; n < 32; n++) begin
         waitOn(1'b1);
         cmp(digitEn_q, 32'h1 << n);
         cmp(32'(segLow_q), 32'(mem[2*n]));
         cmp(32'(segHigh_q), 32'(mem[2*n+1]));
         waitOn(1'b0);
         cmp({digitEn_q[23:0], segLow_q}, 32'hff);
      end
   endtask

   // Outputs are dark while reset is held.
   task automatic resetCheck;
      repeat (5) @(negedge clk);
      cmp(digitEn_q, 32'h0);
      cmp({14'h0, segLow_q, segHigh_q, displayOn_q, writeBusy_q}, 32'h3fffc);
      rst_n = 1'b1;
   endtask

   // Fills all 64 bytes while the scan runs, then checks a frame.
   task automatic loadAll;
      for (int a = 0; a < 64; a++) begin
         mem[a] = 8'(a * 37 + 17);
         sdr_host_model_inst.hostWrite(6'(a), mem[a], 0);
      end
      cmp(32'(writeBusy_q), 32'h0);
      scanFrame();
   endtask

   // Refused writes leave memory alone; a proper one right after lands.
   task automatic refusedWrites;
      sdr_host_model_inst.hostWrite(6'h00, 8'h00, 1);
      sdr_host_model_inst.hostWrite(6'h01, 8'h00, 2);
      mem[63] = 8'h00;
      sdr_host_model_inst.hostWrite(6'h3f, 8'h00, 0);
      scanFrame();
   endtask

   // Prints the verdict and ends the run.
   task automatic stop_test;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         n_errors++;
         stop_test();
      end
   end

   // Main sequence.
   initial begin
      resetCheck();
      loadAll();
      refusedWrites();
      stop_test();
   end
endmodule
